/* prs_cfg.svh */
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

`define PRS_ADDR_RUN_PWR 32'h4004_8238
`define PRS_ADDR_PART_ID 32'h4004_83f4
`define PRS_ADDR_RST_SRC 32'h4004_8300
`define PRS_ADDR_BOD_CTRL 32'h4004_8304
`define PRS_ADDR_STATUS 32'h4004_8308
`define PRS_ADDR_SW_RST 32'h4004_830c
`define PRS_ADDR_CLK_GATE 32'h4004_8310
`define PRS_ADDR_MISC 32'h4004_8314

`define PRS_RUN_PWR_RST 12'hdf0
`define PRS_RUN_PWR_W 12
`define PRS_BIT_RC_OFF 1
`define PRS_BIT_USB_PHY 10
`define PRS_CLK_GATE_RST 32'h0000_001f
`define PRS_CLK_SRC_RC 2'h0
`define PRS_MISC_BOOT_BIT 2
`define PRS_BOD_RSTEN_BIT 4

`define PRS_SRC_POR 0
`define PRS_SRC_EXT 1
`define PRS_SRC_WDT 2
`define PRS_SRC_BOD 3
`define PRS_SRC_SW 4

`define PRS_CLK_MHZ 25
`define PRS_RC_START_US 6
`define PRS_FLASH_PWR_US 100
`define PRS_RC_START_CYC (`PRS_RC_START_US * `PRS_CLK_MHZ)
`define PRS_FLASH_PWR_CYC (`PRS_FLASH_PWR_US * `PRS_CLK_MHZ)
`define PRS_FLASH_INIT_CYC 250

`endif

/* prs_pkg.sv */
`default_nettype none
package prs_pkg;

  typedef enum logic [4:0] {
    PRS_HOLD = 5'b00001,
    PRS_RC_START = 5'b00010,
    PRS_FLASH_PWR = 5'b00100,
    PRS_FLASH_INIT = 5'b01000,
    PRS_RUN = 5'b10000
  } prs_seq_t;

  typedef struct packed {
    prs_seq_t seq;
    logic [11:0] cnt;
    logic [11:0] pwr;
    logic rc_off;
    logic [31:0] clk_gate;
    logic [1:0] clk_src;
    logic boot_map;
    logic [1:0] bod_irq_lvl;
    logic [1:0] bod_rst_lvl;
    logic bod_rst_en;
    logic [4:0] rst_src;
    logic sw_req;
    logic sys_rst;
    logic bod_irq;
    logic [31:0] rdata;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
  } prs_state_t;

endpackage : prs_pkg
`default_nettype wire

/* prs_sequencer.sv */
`include "prs_cfg.svh"
`default_nettype none
module prs_sequencer #(
  // arbitrary neutral value
  parameter logic [31:0] PART_ID = 32'h0a5a_0001
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic ext_reset_n_i,
  input wire logic wdt_reset_i,
  input wire logic por_i,
  input wire logic [3:0] bod_below_i,
  input wire logic rc_clk_gated_i,
  input wire logic core_low_power_i,
  output logic [10:0] power_off_o,
  output logic rc_gate_req_o,
  output logic usb_suspend_o,
  output logic flash_power_on_o,
  output logic flash_init_o,
  output logic sys_reset_o,
  output logic boot_rom_map_o,
  output logic [1:0] sys_clk_src_o,
  output logic [31:0] clk_gate_o,
  output logic bod_irq_o,
  output logic debug_allow_o
);
  import prs_pkg::*;

  localparam logic [11:0] RC_CYC = 12'(`PRS_RC_START_CYC);
  localparam logic [11:0] FLASH_CYC = 12'(`PRS_FLASH_PWR_CYC);
  localparam logic [11:0] INIT_CYC = 12'(`PRS_FLASH_INIT_CYC);

  prs_state_t cur_reg;
  prs_state_t cur_next;

  logic [3:0] cmp;
  logic ext_n;
  logic wdt;
  logic por;
  logic gated;
  logic bod_force;
  logic [4:0] src_now;
  logic any_src;
  logic [11:0] wr_pwr;

  // synchronised pin view: only second stage is read
  assign cmp = cur_reg.pin_s2[3:0];
  assign ext_n = cur_reg.pin_s2[4];
  assign wdt = cur_reg.pin_s2[5];
  assign por = cur_reg.pin_s2[6];
  assign gated = cur_reg.pin_s2[7];

  assign bod_force = cur_reg.bod_rst_en & cmp[cur_reg.bod_rst_lvl];

  always_comb begin
    src_now = 5'h00;
    src_now[`PRS_SRC_POR] = por;
    src_now[`PRS_SRC_EXT] = ~ext_n;
    src_now[`PRS_SRC_WDT] = wdt;
    src_now[`PRS_SRC_BOD] = bod_force;
    src_now[`PRS_SRC_SW] = cur_reg.sw_req;
  end

  assign any_src = |src_now;

  assign wr_pwr = reg_wdata_i[`PRS_RUN_PWR_W-1:0];

  always_comb begin
    cur_next = cur_reg;
    cur_next.pin_s1 = {rc_clk_gated_i, por_i, wdt_reset_i,
                       ext_reset_n_i, bod_below_i};
    cur_next.pin_s2 = cur_reg.pin_s1;
    cur_next.sw_req = 1'b0;
    cur_next.rdata = 32'h0000_0000;

    // sequencer: any source restarts from the hold state
    unique case (cur_reg.seq)
      PRS_HOLD: begin
        cur_next.cnt = 12'h000;
        if (!any_src) begin
          cur_next.seq = PRS_RC_START;
        end
      end
      PRS_RC_START: begin
        if (cur_reg.cnt == RC_CYC - 12'h001) begin
          cur_next.cnt = 12'h000;
          cur_next.seq = PRS_FLASH_PWR;
        end else begin
          cur_next.cnt = cur_reg.cnt + 12'h001;
        end
      end
      PRS_FLASH_PWR: begin
        if (cur_reg.cnt == FLASH_CYC - 12'h001) begin
          cur_next.cnt = 12'h000;
          cur_next.seq = PRS_FLASH_INIT;
        end else begin
          cur_next.cnt = cur_reg.cnt + 12'h001;
        end
      end
      PRS_FLASH_INIT: begin
        if (cur_reg.cnt == INIT_CYC - 12'h001) begin
          cur_next.cnt = 12'h000;
          cur_next.seq = PRS_RUN;
        end else begin
          cur_next.cnt = cur_reg.cnt + 12'h001;
        end
      end
      PRS_RUN: begin
        cur_next.cnt = 12'h000;
      end
      default: begin
        cur_next.seq = PRS_HOLD;
        cur_next.cnt = 12'h000;
      end
    endcase

    if (any_src) begin
      cur_next.seq = PRS_HOLD;
      cur_next.cnt = 12'h000;
    end

    cur_next.sys_rst = (cur_next.seq != PRS_RUN);

    cur_next.bod_irq = cmp[cur_reg.bod_irq_lvl];

    // register writes; accepted even while the core is held
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `PRS_ADDR_RUN_PWR: begin
          cur_next.pwr = wr_pwr;
        end
        `PRS_ADDR_RST_SRC: begin
          cur_next.rst_src = cur_reg.rst_src & ~reg_wdata_i[4:0];
        end
        `PRS_ADDR_BOD_CTRL: begin
          cur_next.bod_irq_lvl = reg_wdata_i[1:0];
          cur_next.bod_rst_lvl = reg_wdata_i[3:2];
          cur_next.bod_rst_en = reg_wdata_i[`PRS_BOD_RSTEN_BIT];
        end
        `PRS_ADDR_SW_RST: begin
          cur_next.sw_req = reg_wdata_i[0];
        end
        `PRS_ADDR_CLK_GATE: begin
          cur_next.clk_gate = reg_wdata_i;
        end
        `PRS_ADDR_MISC: begin
          cur_next.clk_src = reg_wdata_i[1:0];
          cur_next.boot_map = reg_wdata_i[`PRS_MISC_BOOT_BIT];
        end
        default: begin
        end
      endcase
    end

    // sticky source flags: a new event beats a clear
    cur_next.rst_src = cur_next.rst_src | src_now;

    // run-time registers other than BOD control and reset source back to defaults on any reset
    if (any_src) begin
      cur_next.pwr = `PRS_RUN_PWR_RST;
      cur_next.clk_gate = `PRS_CLK_GATE_RST;
      cur_next.clk_src = `PRS_CLK_SRC_RC;
      // boot rom mapped at address 0
      cur_next.boot_map = 1'b1;
    end

    // power-up at once, power-down only once gated
    cur_next.rc_off = cur_next.pwr[`PRS_BIT_RC_OFF] & gated;

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `PRS_ADDR_RUN_PWR: begin
          cur_next.rdata = {20'h00000, cur_reg.pwr};
        end
        `PRS_ADDR_PART_ID: begin
          cur_next.rdata = PART_ID;
        end
        `PRS_ADDR_RST_SRC: begin
          cur_next.rdata = {27'h0000000, cur_reg.rst_src};
        end
        `PRS_ADDR_BOD_CTRL: begin
          cur_next.rdata = {27'h0000000, cur_reg.bod_rst_en,
                            cur_reg.bod_rst_lvl, cur_reg.bod_irq_lvl};
        end
        `PRS_ADDR_STATUS: begin
          cur_next.rdata = {19'h00000, cur_reg.sys_rst, 3'h0,
                            cur_reg.seq, 3'h0, cur_reg.bod_irq};
        end
        `PRS_ADDR_CLK_GATE: begin
          cur_next.rdata = cur_reg.clk_gate;
        end
        `PRS_ADDR_MISC: begin
          cur_next.rdata = {29'h00000000, cur_reg.boot_map,
                            cur_reg.clk_src};
        end
        default: begin
          cur_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cur_reg.seq <= PRS_HOLD;
      cur_reg.cnt <= 12'h000;
      cur_reg.pwr <= `PRS_RUN_PWR_RST;
      cur_reg.rc_off <= 1'b0;
      cur_reg.clk_gate <= `PRS_CLK_GATE_RST;
      cur_reg.clk_src <= `PRS_CLK_SRC_RC;
      cur_reg.boot_map <= 1'b1;
      cur_reg.bod_irq_lvl <= 2'h0;
      cur_reg.bod_rst_lvl <= 2'h0;
      cur_reg.bod_rst_en <= 1'b0;
      cur_reg.rst_src <= 5'h01;
      cur_reg.sw_req <= 1'b0;
      cur_reg.sys_rst <= 1'b1;
      cur_reg.bod_irq <= 1'b0;
      cur_reg.rdata <= 32'h0000_0000;
      // pin released, no source, until the pins are seen
      cur_reg.pin_s1 <= 8'h10;
      cur_reg.pin_s2 <= 8'h10;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign reg_rdata_o = cur_reg.rdata;

  always_comb begin
    power_off_o = cur_reg.pwr[10:0];
    power_off_o[`PRS_BIT_RC_OFF] = cur_reg.rc_off;
    // reserved position drives no block
    power_off_o[9] = 1'b0;
  end

  assign rc_gate_req_o = cur_reg.pwr[`PRS_BIT_RC_OFF];
  assign usb_suspend_o = cur_reg.pwr[`PRS_BIT_USB_PHY];
  assign flash_power_on_o = (cur_reg.seq != PRS_HOLD) &&
                            (cur_reg.seq != PRS_RC_START);
  assign flash_init_o = (cur_reg.seq == PRS_FLASH_INIT);
  assign sys_reset_o = cur_reg.sys_rst;
  assign boot_rom_map_o = cur_reg.boot_map;
  assign sys_clk_src_o = cur_reg.clk_src;
  assign clk_gate_o = cur_reg.clk_gate;
  assign bod_irq_o = cur_reg.bod_irq;
  assign debug_allow_o = ~core_low_power_i;

endmodule // prs_sequencer
`default_nettype wire

/* prs_sequencer_properties.sv */
`include "prs_cfg.svh"
`default_nettype none
module prs_sequencer_properties #(
  parameter logic [31:0] PART_ID = 32'h0a5a_0001
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic ext_reset_n_i,
  input wire logic core_low_power_i,
  input wire logic [10:0] power_off_o,
  input wire logic rc_gate_req_o,
  input wire logic usb_suspend_o,
  input wire logic flash_power_on_o,
  input wire logic flash_init_o,
  input wire logic sys_reset_o,
  input wire logic boot_rom_map_o,
  input wire logic [1:0] sys_clk_src_o,
  input wire logic [31:0] clk_gate_o,
  input wire logic debug_allow_o
);
  // run length of the flash init phase
  logic [8:0] init_reg;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      init_reg <= '0;
    end else begin
      init_reg <= flash_init_o ? init_reg + 9'h1 : 9'h0;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_part_id_read: assert property ($past(reg_rd_i) &&
    $past(reg_addr_i) == `PRS_ADDR_PART_ID |-> reg_rdata_o == PART_ID)
    else $error("part id read wrong");
  a_usb_suspend: assert property (
    usb_suspend_o == power_off_o[10]) else $error("usb suspend wrong");
  a_rc_gate_first: assert property (
    power_off_o[1] |-> rc_gate_req_o) else $error("rc off ungated");
  a_pin_reset: assert property (
    !ext_reset_n_i |-> ##[1:3] sys_reset_o) else $error("pin ignored");
  a_release_ready: assert property ($fell(sys_reset_o) |->
    ext_reset_n_i && flash_power_on_o && !flash_init_o)
    else $error("early release");
  a_init_length: assert property (
    $fell(flash_init_o) && flash_power_on_o |-> init_reg == 9'h0fa)
    else $error("flash init length wrong");
  a_boot_clock: assert property ($fell(sys_reset_o) |->
    boot_rom_map_o && sys_clk_src_o == `PRS_CLK_SRC_RC)
    else $error("boot map or clock wrong");
  a_reset_config: assert property ($rose(sys_reset_o) |->
    ##1 power_off_o == 11'h5f0 && clk_gate_o == `PRS_CLK_GATE_RST)
    else $error("defaults not reloaded");
  a_debug_gate: assert property (
    debug_allow_o == !core_low_power_i) else $error("debug gate wrong");
endmodule // prs_sequencer_properties
bind prs_sequencer prs_sequencer_properties #(.PART_ID(PART_ID)) u_chk (.*);
`default_nettype wire

/* tb_prs_sequencer.sv */
`include "prs_cfg.svh"
`default_nettype none
module tb_prs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // arbitrary value
  localparam logic [31:0] PID = 32'h0c3c_7e11;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic ext_reset_n_i = 1'b1;
  logic wdt_reset_i = 1'b0;
  logic por_i = 1'b0;
  logic [3:0] bod_below_i = '0;
  logic rc_clk_gated_i = 1'b0;
  logic core_low_power_i = 1'b0;
  logic [31:0] reg_rdata_o, clk_gate_o;
  logic [10:0] power_off_o;
  logic [1:0] sys_clk_src_o;
  logic rc_gate_req_o, usb_suspend_o, flash_power_on_o, flash_init_o;
  logic sys_reset_o, boot_rom_map_o, bod_irq_o, debug_allow_o;
  int error_cnt = 0;
  int num_checks = 0;
  logic [15:0] lfsr_reg = 16'hd5bb;
  logic [4:0] src_bits [4] = '{5'h04, 5'h01, 5'h08, 5'h10};
  prs_sequencer #(.PART_ID(PID)) u_dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .ext_reset_n_i(ext_reset_n_i),
    .wdt_reset_i(wdt_reset_i),
    .por_i(por_i),
    .bod_below_i(bod_below_i),
    .rc_clk_gated_i(rc_clk_gated_i),
    .core_low_power_i(core_low_power_i),
    .power_off_o(power_off_o),
    .rc_gate_req_o(rc_gate_req_o),
    .usb_suspend_o(usb_suspend_o),
    .flash_power_on_o(flash_power_on_o),
    .flash_init_o(flash_init_o),
    .sys_reset_o(sys_reset_o),
    .boot_rom_map_o(boot_rom_map_o),
    .sys_clk_src_o(sys_clk_src_o),
    .clk_gate_o(clk_gate_o),
    .bod_irq_o(bod_irq_o),
    .debug_allow_o(debug_allow_o)
  );
  always #20 core_clk_i = ~core_clk_i;
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // upper reserved bits never stick
  function automatic logic [31:0] exp_pwr(input logic [31:0] v);
    return {20'h0, v[11:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask
  // bounded so a stuck sequencer cannot hang the run
  task automatic wait_run(input int lo);
    int n;
    n = 0;
    while (sys_reset_o !== 1'b0 && n < 4000) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    #1;
    chk(32'(n >= lo && n < 2920), 32'h1);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #2_400_000;
    error_cnt++;
    results();
  end
  initial begin
    int i;
    logic [31:0] v;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    chk({sys_reset_o, boot_rom_map_o, sys_clk_src_o}, 32'hc);
    rd(`PRS_ADDR_RUN_PWR, 32'hdf0);
    wr(`PRS_ADDR_PART_ID, ~PID);
    rd(`PRS_ADDR_PART_ID, PID);
    rd(32'h4004_8400, 32'h0);
    ext_reset_n_i <= 1'b0;
    repeat (20) @(posedge core_clk_i);
    ext_reset_n_i <= 1'b1;
    wait_run(2901);
    chk({flash_power_on_o, flash_init_o}, 32'h2);
    chk(clk_gate_o, `PRS_CLK_GATE_RST);
    for (i = 0; i < 8; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      core_low_power_i <= lfsr_reg[3];
      v = {lfsr_reg, lfsr_reg} & 32'hffff_fdfd | 32'h800;
      if (i == 0) v = 32'hffff_fdfd;
      if (i == 1) v = 32'h800;
      // usb pll in use keeps main osc powered
      if (!v[8]) v[5] = 1'b0;
      wr(`PRS_ADDR_RUN_PWR, v);
      chk(power_off_o, v[10:0]);
      chk(usb_suspend_o, v[10]);
      rd(`PRS_ADDR_RUN_PWR, exp_pwr(v));
      chk(debug_allow_o, !core_low_power_i);
    end
    wr(`PRS_ADDR_RUN_PWR, 32'h802);
    chk({rc_gate_req_o, power_off_o[1]}, 32'h2);
    rc_clk_gated_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
    chk(power_off_o[1], 1'b1);
    rc_clk_gated_i <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(`PRS_ADDR_RUN_PWR, 32'h800);
      wr(`PRS_ADDR_RST_SRC, 32'h1f);
      wr(`PRS_ADDR_BOD_CTRL, 32'h1a);
      case (i)
        0: wdt_reset_i <= 1'b1;
        1: por_i <= 1'b1;
        2: bod_below_i <= 4'h4;
        default: wr(`PRS_ADDR_SW_RST, 32'h1);
      endcase
      repeat (4) @(posedge core_clk_i);
      #1;
      chk(bod_irq_o, i == 2);
      chk(sys_reset_o, 1'b1);
      v = (i == 3) ? 32'h1020 : 32'h1010 | 32'(i == 2);
      rd(`PRS_ADDR_STATUS, v);
      wdt_reset_i <= 1'b0;
      por_i <= 1'b0;
      bod_below_i <= 4'h0;
      rd(`PRS_ADDR_RST_SRC, src_bits[i]);
      rd(`PRS_ADDR_RUN_PWR, 32'hdf0);
      wait_run(2890);
      rd(`PRS_ADDR_MISC, 32'h4);
    end
    results();
  end
endmodule // tb_prs_sequencer
`default_nettype wire
